//--- design/eppcs_map.svh
// Behaviour
// - host strobe bit forces write mode in cycles
// - write with direction bit set runs read
// - 1.9 write holds ready low until finishable
// - wait already low: finish when wait rises
// - 1.9 wait high at start: hold until low
// - 1.9 write drives byte, write and strobe together
// - wait rise ends strobe, releases ready
// - 1.9 read floats bus, sets direction, strobes
// - wait rise in read captures byte, releases
// - 1.9 read finishes on wait rise
// - idle port follows control register bits
// - 1.7 watchdog aborts and flags timeout
// - 1.7 holds ready low while wait low
// - 1.7 write drives byte and strobe at start
// - 1.7 read end drops strobe, latches byte
// - timeout flag cleared by reset or one
// - 1.9 watchdog runs until wait deasserts
// - direction low unless bit set or read
`ifndef EPPCS_MAP_SVH
`define EPPCS_MAP_SVH
// register indices, byte address is four times the index
`define EPPCS_IDX_DATA 4'h0
`define EPPCS_IDX_STAT 4'h1
`define EPPCS_IDX_CTRL 4'h2
`define EPPCS_IDX_EADR 4'h3
`define EPPCS_IDX_ED0  4'h4
`define EPPCS_IDX_ED3  4'h7
`define EPPCS_IDX_MODE 4'h8
// field positions
`define EPPCS_CTRL_STB  0
`define EPPCS_CTRL_AFD  1
`define EPPCS_CTRL_INI  2
`define EPPCS_CTRL_SLI  3
`define EPPCS_CTRL_PCD  5
`define EPPCS_STAT_TMO  0
`define EPPCS_MODE_EN   0
`define EPPCS_MODE_17   1
// reset values
`define EPPCS_CTRL_RST  6'h00
`define EPPCS_MODE_RST  2'h0
`define EPPCS_PD_RST    8'h00
// timing
`define EPPCS_TMO_NS    10000
`define EPPCS_CLK_NS    10
`define EPPCS_TMO_CYC   ((`EPPCS_TMO_NS + `EPPCS_CLK_NS - 1) / `EPPCS_CLK_NS)
`endif

//--- design/eppcs_pkg.sv
package eppcs_pkg;
  // cycle sequencer states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WLOW,
    ST_STB,
    ST_DONE
  } eppcs_state_t;
endpackage

//--- design/eppcs_sync.sv
`timescale 1ns/1ns
`default_nettype none
module eppcs_sync #(
  parameter int W = 1
) (
  input  wire logic         CLK_I,
  input  wire logic         RST_I,
  input  wire logic [W-1:0] IN_I,
  output logic      [W-1:0] OUT_O
);
  // two stage synchroniser state
  typedef struct packed {
    logic [W-1:0] meta;  // first stage, read only by second
    logic [W-1:0] sync;  // second stage
  } eppcs_sync_t;

  eppcs_sync_t s_r;
  eppcs_sync_t s_nxt;

  // shift pin level through both stages
  always_comb begin
    s_nxt.meta = IN_I;
    s_nxt.sync = s_r.meta;
  end

  // reset to all zero, never to a port value
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign OUT_O = s_r.sync;
endmodule
`default_nettype wire

//--- design/eppcs_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "eppcs_map.svh"
module eppcs_top import eppcs_pkg::*; #(
  parameter int ADDR_W  = 8,
  parameter int TMO_CYC = `EPPCS_TMO_CYC,
  parameter int WDOG_W  = $clog2(TMO_CYC + 1)
) (
  input  wire logic              CLK_I,
  input  wire logic              RST_I,
  input  wire logic              PSEL_I,
  input  wire logic              PENABLE_I,
  input  wire logic              PWRITE_I,
  input  wire logic [ADDR_W-1:0] PADDR_I,
  input  wire logic [31:0]       PWDATA_I,
  output logic      [31:0]       PRDATA_O,
  output logic                   PREADY_O,
  output logic                   PSLVERR_O,
  input  wire logic [7:0]        PORT_DATA_BUS_I,
  output logic      [7:0]        PORT_DATA_BUS_O,
  output logic                   PORT_DATA_BUS_OE_O,
  input  wire logic              PERIPHERAL_WAIT_N_I,
  output logic                   DATA_STROBE_N_O,
  output logic                   ADDRESS_STROBE_N_O,
  output logic                   WRITE_INDICATE_N_O,
  output logic                   PORT_DIRECTION_OUT_O,
  output logic                   STROBE_N_O,
  output logic                   AUTOFD_N_O,
  output logic                   INIT_N_O,
  output logic                   SLCTIN_N_O,
  input  wire logic              ERR_N_I,
  input  wire logic              SLCT_I,
  input  wire logic              PE_I,
  input  wire logic              ACK_N_I,
  input  wire logic              BUSY_I
);
  // whole block state
  typedef struct packed {
    eppcs_state_t      st;      // sequencer state
    logic [5:0]        ctrl;    // control port bits
    logic [1:0]        mode;    // epp enable, 1.7 select
    logic [7:0]        pd;      // byte for the port bus
    logic [31:0]       rdata;   // read data to the bus
    logic              tmo;     // timeout_flag
    logic [WDOG_W-1:0] wdog;    // watchdog count
    logic              cyc_wr;  // cycle is a true write
    logic              cyc_adr; // cycle uses address strobe
    logic              cyc17;   // cycle runs 1.7 style
  } eppcs_regs_t;

  eppcs_regs_t s_r;
  eppcs_regs_t s_nxt;

  logic [13:0] sync_out;  // synchronised pin levels
  logic [7:0]  pd_s;      // port data, synchronised
  logic        wait_s;    // peripheral_wait, high means not waiting
  logic        err_n_s;
  logic        slct_s;
  logic        pe_s;
  logic        ack_n_s;
  logic        busy_s;
  logic [3:0]  idx;       // decoded register index
  logic        mapped;    // address hits a register
  logic        epp_sel;   // access targets an epp port
  logic        control_direction_bit;       // control_direction_bit
  logic        eff_wr;    // write mode inside a cycle
  logic        in_cyc;    // port driven by the sequencer
  logic        abort;     // watchdog terminal count
  logic        acc;       // apb access phase

  // all pins cross into the clock domain first
  eppcs_sync #(
    .W (14)
  ) u_sync (
    .CLK_I (CLK_I),
    .RST_I (RST_I),
    .IN_I  ({PORT_DATA_BUS_I, PERIPHERAL_WAIT_N_I, ERR_N_I, SLCT_I,
             PE_I, ACK_N_I, BUSY_I}),
    .OUT_O (sync_out)
  );

  assign {pd_s, wait_s, err_n_s, slct_s, pe_s, ack_n_s, busy_s} = sync_out;

  // word index of an aligned byte address
  function automatic logic [3:0] reg_idx(input logic [ADDR_W-1:0] a);
    reg_idx = a[5:2];
  endfunction

  // true for the epp address and data ports
  function automatic logic is_epp(input logic [3:0] i);
    is_epp = (i >= `EPPCS_IDX_EADR) && (i <= `EPPCS_IDX_ED3);
  endfunction

  // decode; upper address bits must be clear
  always_comb begin
    idx    = reg_idx(PADDR_I);
    mapped = (PADDR_I[1:0] == 2'h0) && (PADDR_I[ADDR_W-1:6] == '0)
             && (idx <= `EPPCS_IDX_MODE);
  end

  assign epp_sel = mapped && is_epp(idx) && s_r.mode[`EPPCS_MODE_EN];
  assign control_direction_bit     = s_r.ctrl[`EPPCS_CTRL_PCD];
  assign eff_wr  = s_r.cyc_wr | s_r.ctrl[`EPPCS_CTRL_STB];
  assign in_cyc  = (s_r.st == ST_STB) || (s_r.st == ST_DONE);
  assign abort   = (s_r.wdog == WDOG_W'(TMO_CYC - 1));
  assign acc     = PSEL_I & PENABLE_I;

  // ready stays low for the whole epp cycle
  assign PREADY_O  = !epp_sel || (s_r.st == ST_DONE);
  assign PSLVERR_O = PSEL_I && PENABLE_I && !mapped;
  assign PRDATA_O  = s_r.rdata;

  // port side outputs; idle port follows control bits
  assign PORT_DATA_BUS_O      = s_r.pd;
  assign PORT_DATA_BUS_OE_O   = in_cyc ? eff_wr : !control_direction_bit;
  assign WRITE_INDICATE_N_O   = in_cyc ? !eff_wr : control_direction_bit;
  assign PORT_DIRECTION_OUT_O = in_cyc ? !eff_wr : control_direction_bit;
  assign DATA_STROBE_N_O      = !((s_r.st == ST_STB) && !s_r.cyc_adr);
  assign ADDRESS_STROBE_N_O   = !((s_r.st == ST_STB) && s_r.cyc_adr);
  assign STROBE_N_O           = !s_r.ctrl[`EPPCS_CTRL_STB];
  assign AUTOFD_N_O           = !s_r.ctrl[`EPPCS_CTRL_AFD];
  assign INIT_N_O             = s_r.ctrl[`EPPCS_CTRL_INI];
  assign SLCTIN_N_O           = !s_r.ctrl[`EPPCS_CTRL_SLI];

  // next state: sequencer, registers, watchdog
  always_comb begin
    logic tmo_set;
    tmo_set = 1'b0;
    s_nxt   = s_r;
    unique case (s_r.st)
      ST_IDLE: begin
        // cycle starts with the host access phase
        if (acc && epp_sel) begin
          s_nxt.cyc_wr  = PWRITE_I && !control_direction_bit;
          s_nxt.cyc_adr = (idx == `EPPCS_IDX_EADR);
          s_nxt.cyc17   = s_r.mode[`EPPCS_MODE_17];
          s_nxt.wdog    = '0;
          if (PWRITE_I) begin
            s_nxt.pd = PWDATA_I[7:0];
          end
          if (s_r.mode[`EPPCS_MODE_17] || !wait_s) begin
            s_nxt.st = ST_STB;
          end else begin
            s_nxt.st = ST_WLOW;
          end
        end
      end
      ST_WLOW: begin
        // strobe and write stay put until wait goes low
        s_nxt.wdog = s_r.wdog + 1'b1;
        if (!wait_s) begin
          s_nxt.st = ST_STB;
        end else if (abort) begin
          tmo_set  = 1'b1;
          s_nxt.st = ST_DONE;
        end
      end
      ST_STB: begin
        // completion wins over a same-cycle timeout
        s_nxt.wdog = s_r.wdog + 1'b1;
        if (wait_s) begin
          s_nxt.st = ST_DONE;
          if (!eff_wr) begin
            s_nxt.rdata = {24'h0, pd_s};
          end
        end else if (abort) begin
          tmo_set  = 1'b1;
          s_nxt.st = ST_DONE;
        end
      end
      ST_DONE: begin
        // ready is high here, so the host takes it now
        s_nxt.st = ST_IDLE;
      end
    endcase

    // plain register reads load in the setup phase
    if (PSEL_I && !PENABLE_I && !PWRITE_I && !(mapped && is_epp(idx))) begin
      s_nxt.rdata = 32'h0;
      if (!mapped) begin
        // index bits alone would alias, so unmapped offsets read zero
        s_nxt.rdata = 32'h0;
      end else if (idx == `EPPCS_IDX_DATA) begin
        s_nxt.rdata = {24'h0, pd_s};
      end else if (idx == `EPPCS_IDX_STAT) begin
        s_nxt.rdata = {24'h0, !busy_s, ack_n_s, pe_s, slct_s, err_n_s,
                       2'h0, s_r.tmo};
      end else if (idx == `EPPCS_IDX_CTRL) begin
        s_nxt.rdata = {26'h0, s_r.ctrl};
      end else if (idx == `EPPCS_IDX_MODE) begin
        s_nxt.rdata = {30'h0, s_r.mode};
      end
    end
    // epp ports read as zero while epp is disabled
    if (PSEL_I && !PENABLE_I && mapped && is_epp(idx)
        && !s_r.mode[`EPPCS_MODE_EN]) begin
      s_nxt.rdata = 32'h0;
    end

    // plain register writes complete in one access cycle
    if (acc && PWRITE_I && mapped && !is_epp(idx)) begin
      if (idx == `EPPCS_IDX_DATA) begin
        s_nxt.pd = PWDATA_I[7:0];
      end else if (idx == `EPPCS_IDX_CTRL) begin
        s_nxt.ctrl = PWDATA_I[5:0];
      end else if (idx == `EPPCS_IDX_MODE) begin
        s_nxt.mode = PWDATA_I[1:0];
      end else if (idx == `EPPCS_IDX_STAT && PWDATA_I[`EPPCS_STAT_TMO]) begin
        s_nxt.tmo = 1'b0;
      end
    end
    // set wins over a clear in the same cycle
    if (tmo_set) begin
      s_nxt.tmo = 1'b1;
    end
  end

  // single state register, synchronous reset
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      s_r.st      <= ST_IDLE;
      s_r.ctrl    <= `EPPCS_CTRL_RST;
      s_r.mode    <= `EPPCS_MODE_RST;
      s_r.pd      <= `EPPCS_PD_RST;
      s_r.rdata   <= 32'h0;
      s_r.tmo     <= 1'b0;
      s_r.wdog    <= '0;
      s_r.cyc_wr  <= 1'b0;
      s_r.cyc_adr <= 1'b0;
      s_r.cyc17   <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // checks, all on the one clock domain
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  a_rdy_while_wait: assert property (
    (s_r.st inside {ST_WLOW, ST_STB}) && epp_sel |-> !PREADY_O)
    else $error("ready released during an open cycle");
  a_wait_finish: assert property (
    (s_r.st == ST_STB) && wait_s |=> (s_r.st == ST_DONE) && PREADY_O
    ##1 (s_r.st == ST_IDLE))
    else $error("cycle did not finish on wait rise");
  a_hold_pins: assert property (
    (s_r.st == ST_WLOW) |-> DATA_STROBE_N_O && ADDRESS_STROBE_N_O
    && (WRITE_INDICATE_N_O == control_direction_bit))
    else $error("pins moved before wait went low");
  a_write_drive: assert property (
    (s_r.st == ST_STB) && eff_wr |-> PORT_DATA_BUS_OE_O
    && !WRITE_INDICATE_N_O && !PORT_DIRECTION_OUT_O)
    else $error("write strobe without driven bus");
  a_read_float: assert property (
    (s_r.st == ST_STB) && !eff_wr |-> !PORT_DATA_BUS_OE_O
    && WRITE_INDICATE_N_O && PORT_DIRECTION_OUT_O)
    else $error("read strobe with bus driven");
  a_strb_override: assert property (
    in_cyc && s_r.ctrl[`EPPCS_CTRL_STB] |-> PORT_DATA_BUS_OE_O
    && !WRITE_INDICATE_N_O)
    else $error("strobe bit did not force write mode");
  a_pcd_read: assert property (
    (s_r.st == ST_IDLE) && acc && epp_sel && PWRITE_I && control_direction_bit
    && !s_r.ctrl[`EPPCS_CTRL_STB] |=> !s_r.cyc_wr)
    else $error("write with direction bit set did not read");
  a_read_capture: assert property (
    (s_r.st == ST_STB) && !eff_wr && wait_s |=> PRDATA_O == {24'h0, $past(pd_s)})
    else $error("read byte not captured");
  a_wdog_abort: assert property (
    (s_r.st inside {ST_WLOW, ST_STB}) && abort && !$changed(wait_s) && (
    (s_r.st == ST_STB) ? !wait_s : wait_s)
    |=> s_r.tmo && (s_r.st == ST_DONE))
    else $error("watchdog did not abort");
  a_tmo_sticky: assert property (
    s_r.tmo && !(acc && PWRITE_I && mapped && (idx == `EPPCS_IDX_STAT)
    && PWDATA_I[`EPPCS_STAT_TMO]) |=> s_r.tmo)
    else $error("timeout flag lost without clear");
  a_idle_port: assert property (
    (s_r.st inside {ST_IDLE, ST_WLOW}) |-> (PORT_DATA_BUS_OE_O == !control_direction_bit)
    && (PORT_DIRECTION_OUT_O == control_direction_bit))
    else $error("idle port not following control bits");
  // ready pulse, strobe window and watchdog range
  a_done_ready: assert property (
    (s_r.st == ST_DONE) |-> PREADY_O ##1 (s_r.st == ST_IDLE))
    else $error("done state without a one cycle ready");
  a_strobe_idle: assert property (
    (s_r.st != ST_STB) |-> DATA_STROBE_N_O && ADDRESS_STROBE_N_O)
    else $error("strobe low outside the strobe state");
  a_wdog_bound: assert property (
    (s_r.st inside {ST_WLOW, ST_STB}) |-> (s_r.wdog < WDOG_W'(TMO_CYC)))
    else $error("watchdog ran past its terminal count");

  c_write_19: cover property (
    (s_r.st == ST_STB) && !s_r.cyc17 && s_r.cyc_wr ##1 (s_r.st == ST_DONE));
  c_read_19: cover property (
    (s_r.st == ST_WLOW) ##[1:20] (s_r.st == ST_STB) && !s_r.cyc_wr);
  c_cycle_17: cover property ((s_r.st == ST_DONE) && s_r.cyc17 && !s_r.tmo);
  c_timeout: cover property ($rose(s_r.tmo));
  // write turned into a read by the direction bit
  c_write_redirect: cover property ((s_r.st == ST_STB) && PWRITE_I && !eff_wr);
endmodule
`default_nettype wire

//--- verif/eppcs_periph.sv
`timescale 1ns/1ns
`default_nettype none
// behavioural epp peripheral: one handshake per strobe, answers DLY+1 cycles after strobe fall
module eppcs_periph #(
  parameter int DLY = 3  // strobe cycles counted before answering; wait releases DLY+1 cycles after strobe fall
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       data_strobe_n_i,
  input  wire logic       address_strobe_n_i,
  input  wire logic       write_indicate_n_i,
  input  wire logic [7:0] bus_i,
  input  wire logic       ready_i,   // low keeps wait high between cycles
  input  wire logic       mute_i,    // never answers, so the watchdog must fire
  input  wire logic [7:0] rd_byte_i,
  output logic            wait_n_o,
  output logic      [7:0] data_o,
  output logic      [7:0] got_o,
  output logic            got_addr_o,
  output logic      [7:0] n_got_o
);
  logic       busy;  // answered, waiting for the strobe to end
  logic [7:0] cnt;   // cycles since strobe fell
  logic       stb;   // either strobe active
  assign stb = !(data_strobe_n_i && address_strobe_n_i);
  // handshake sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy     <= 1'b0;
      cnt      <= 8'h00;
      wait_n_o <= 1'b0;
      data_o   <= 8'h00;
      n_got_o  <= 8'h00;
    end else if (stb && !busy) begin
      cnt <= cnt + 8'h01;
      // byte driven before wait rises
      if (write_indicate_n_i) data_o <= rd_byte_i;
      if (cnt == 8'(DLY) && !mute_i) begin
        wait_n_o <= 1'b1;
        busy     <= 1'b1;
        // latched well before the strobe ends
        if (!write_indicate_n_i) begin
          got_o      <= bus_i;
          got_addr_o <= ~address_strobe_n_i;
          n_got_o    <= n_got_o + 8'h01;
        end
      end
    end else if (!stb) begin
      // released bus must not keep showing the stale byte
      if (busy || cnt != 8'h00) data_o <= ~data_o;
      busy     <= 1'b0;
      cnt      <= 8'h00;
      wait_n_o <= !ready_i;
    end
  end
endmodule
`default_nettype wire

//--- verif/epp_cycle_sequencer_test.sv
`timescale 1ns/1ns
`default_nettype none
module epp_cycle_sequencer_test;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, bus, dev_o, per_d, got, n_got, n0;
  logic [31:0] pwdata, prdata, q;
  logic        dev_oe, wait_n, ds_n, as_n, wr_n, port_direction_out, stb_n, afd_n, init_n, sli_n;
  logic        err_n, slct, pe, ack_n, busy, ready, mute, got_addr, fwd, e;
  logic [7:0]  rd_byte;
  logic [6:0]  outs;  // control pins, direction and drive enable
  logic [7:0]  adr [3] = '{8'h0c, 8'h10, 8'h1c};  // address port, first and last data port
  int          n_fail = 0;
  int          checked = 0;
  assign bus  = dev_oe ? dev_o : per_d;  // resolved port bus
  assign outs = {stb_n, afd_n, init_n, sli_n, port_direction_out, wr_n, dev_oe};
  // 100 mhz clock
  initial clk = 1'b0;
  always #5 clk = ~clk;
  eppcs_top #(.TMO_CYC(40)) eppcs_top_inst (.CLK_I(clk), .RST_I(rst), .PSEL_I(psel),
    .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .PORT_DATA_BUS_I(bus),
    .PORT_DATA_BUS_O(dev_o), .PORT_DATA_BUS_OE_O(dev_oe), .PERIPHERAL_WAIT_N_I(wait_n),
    .DATA_STROBE_N_O(ds_n), .ADDRESS_STROBE_N_O(as_n), .WRITE_INDICATE_N_O(wr_n),
    .PORT_DIRECTION_OUT_O(port_direction_out), .STROBE_N_O(stb_n), .AUTOFD_N_O(afd_n), .INIT_N_O(init_n),
    .SLCTIN_N_O(sli_n), .ERR_N_I(err_n), .SLCT_I(slct), .PE_I(pe), .ACK_N_I(ack_n),
    .BUSY_I(busy));
  eppcs_periph eppcs_periph_inst (.clk_i(clk), .rst_i(rst), .data_strobe_n_i(ds_n),
    .address_strobe_n_i(as_n), .write_indicate_n_i(wr_n), .bus_i(bus), .ready_i(ready),
    .mute_i(mute), .rd_byte_i(rd_byte), .wait_n_o(wait_n), .data_o(per_d), .got_o(got),
    .got_addr_o(got_addr), .n_got_o(n_got));
  // one comparison
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    checked++;
    if (g !== x) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  // one apb transfer, no fixed wait assumed
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rq, output logic re);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    // ready, read data and error are all taken at the same rising edge
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rq = prdata;
    re = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rq;
    logic        re;
    apb(1'b1, a, d, rq, re);
    chk(32'(re), 32'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] rq;
    logic        re;
    apb(1'b0, a, 32'h0, rq, re);
    chk(rq, x);
    chk(32'(re), 32'(xe));
  endtask
  // verdict, the only exit
  task automatic report_and_stop;
    if (n_fail == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // pin state while any strobe is low
  always @(negedge clk) begin
    if (!rst && !(ds_n && as_n)) begin
      chk(32'({dev_oe, wr_n, port_direction_out}), fwd ? 32'h4 : 32'h3);
      chk(32'(ready), 32'h1);
    end
  end
  // hang guard, run needs a few hundred cycles
  initial begin
    #300000;
    n_fail++;
    report_and_stop;
  end
  // main sequence
  initial begin
    {psel, penable, pwrite} = 3'b000;
    paddr = 8'h00;
    pwdata = 32'h0;
    rst = 1'b1;
    {ready, mute, fwd} = 3'b101;
    rd_byte = 8'h00;
    {err_n, slct, pe, ack_n, busy} = 5'b11000;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk(32'(outs), 32'h69);
    rd(8'h04, 32'h98, 1'b0);
    wr(8'h08, 32'hef);
    rd(8'h08, 32'h2f, 1'b0);
    @(negedge clk);
    chk(32'(outs), 32'h16);
    rd(8'h30, 32'h0, 1'b1);
    rd(8'h10, 32'h0, 1'b0);
    for (int m = 1; m < 4; m += 2) begin
      wr(8'h20, 32'(m));
      for (int i = 0; i < 3; i++) begin
        // middle 1.9 write starts with the peripheral not ready; set early so
        // the synchronised wait is already high when the cycle is taken
        ready <= !(m == 1 && i == 1);
        wr(8'h08, 32'h04);
        fwd = 1'b1;
        n0 = n_got;
        fork
          wr(adr[i], 32'h5a ^ 32'(i));
          begin
            repeat (15) @(posedge clk);
            ready <= 1'b1;
          end
        join
        chk(32'(got), 32'h5a ^ 32'(i));
        chk(32'(got_addr), 32'(i == 0));
        chk(32'(n_got), 32'(n0) + 32'h1);
        wr(8'h08, (m == 3) ? 32'h24 : 32'h04);
        fwd = 1'b0;
        rd_byte <= 8'hc3 ^ 8'(i);
        rd(adr[i], 32'hc3 ^ 32'(i), 1'b0);
      end
    end
    wr(8'h20, 32'h1);
    wr(8'h08, 32'h05);
    fwd = 1'b1;
    apb(1'b0, 8'h10, 32'h0, q, e);
    wr(8'h08, 32'h24);
    fwd = 1'b0;
    n0 = n_got;
    wr(8'h10, 32'h77);
    chk(32'(n_got), 32'(n0));
    rd(8'h04, 32'h98, 1'b0);
    wr(8'h08, 32'h04);
    fwd = 1'b1;
    mute <= 1'b1;
    for (int m = 1; m < 4; m += 2) begin
      wr(8'h20, 32'(m));
      wr(8'h10, 32'h11);
      rd(8'h04, 32'h99, 1'b0);
      wr(8'h04, 32'h0);
      rd(8'h04, 32'h99, 1'b0);
      wr(8'h04, 32'h1);
      rd(8'h04, 32'h98, 1'b0);
    end
    mute <= 1'b0;
    report_and_stop;
  end
endmodule
`default_nettype wire
